// File: logic/cbis_pkg.sv
// constants, field layouts and state codes for the card bring-up responder
package cbis_pkg;
   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_PATTERN = 4'h8;
   localparam int CTRL_SECTOR_BIT = 0;
   localparam int CTRL_BUSY_LSB = 4;
   localparam logic CTRL_SECTOR_RST = 1'b0;
   localparam logic [3:0] CTRL_BUSY_RST = 4'h8;

   // ----------------------------------------------------------------
   // link timing, counted in bus clock periods
   // ----------------------------------------------------------------
   // outlasts the start-up clocks plus one command frame, so early polls see busy
   localparam logic [7:0] POWERUP_CLKS = 8'h90;
   localparam logic [5:0] NCR_CLKS = 6'h02;
   localparam logic [5:0] CMD_BITS = 6'h30;
   localparam logic [5:0] BLK_COLS = 6'h08;
   localparam logic [5:0] BLK_END = 6'h09;

   // ----------------------------------------------------------------
   // command indices, descriptor byte indices, response fields
   // ----------------------------------------------------------------
   localparam logic [5:0] CMD_OP_COND = 6'h01;
   localparam logic [5:0] CMD_SWITCH = 6'h06;
   localparam logic [5:0] CMD_BUSTEST_R = 6'h0e;
   localparam logic [5:0] CMD_BUSTEST_W = 6'h13;
   localparam logic [1:0] SWITCH_WRITE_BYTE = 2'h3;
   localparam logic [7:0] IDX_TIMING_SELECT = 8'hb9;
   localparam logic [7:0] IDX_BUS_WIDTH = 8'hb7;
   localparam logic [7:0] IDX_POWER_CLASS = 8'hbb;
   localparam logic [23:0] OCR_VOLTAGE = 24'hff8080;
   localparam logic [3:0] R1_STATE_TRAN = 4'h4;
   localparam logic [5:0] R3_RSVD_IDX = 6'h3f;
   localparam logic [6:0] R3_RSVD_CRC = 7'h7f;
   localparam logic [6:0] CRC7_POLY = 7'h09;

   // ----------------------------------------------------------------
   // state codes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      CARD_IDLE = 3'b001,
      CARD_READY = 3'b010,
      CARD_INACTIVE = 3'b100
   } cbis_card_t;

   typedef enum logic [6:0] {
      PH_RX = 7'b0000001,
      PH_DECODE = 7'b0000010,
      PH_WAIT = 7'b0000100,
      PH_TXRSP = 7'b0001000,
      PH_BUSY = 7'b0010000,
      PH_RXBLK = 7'b0100000,
      PH_TXBLK = 7'b1000000
   } cbis_ph_t;
endpackage

// File: logic/cbis_card.sv
// card-side responder for operating-condition polling, switch busy and bus test
`timescale 1ns/10ps
module cbis_card (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // register port
   input wire logic [3:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   // card bus pins
   input wire logic i_bus_clk,
   input wire logic i_cmd,
   output logic o_cmd,
   output logic o_cmd_oe,
   input wire logic [7:0] i_dat,
   output logic [7:0] o_dat,
   output logic [7:0] o_dat_oe,
   // applied configuration
   output logic o_timing_select_byte,
   output logic [7:0] o_bus_width
);
   // ----------------------------------------------------------------
   // pin synchronisers and bus clock edges
   // ----------------------------------------------------------------
   logic [2:0] clk_sync;
   logic [1:0] cmd_sync;
   logic [7:0] dat_meta;
   logic [7:0] dat_s;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         // bus clock idles high; a low reset value would fake a rising edge
         clk_sync <= 3'h7;
         cmd_sync <= 2'h3;
         dat_meta <= 8'hff;
         dat_s <= 8'hff;
      end else begin
         clk_sync <= {clk_sync[1:0], i_bus_clk};
         cmd_sync <= {cmd_sync[0], i_cmd};
         dat_meta <= i_dat;
         dat_s <= dat_meta;
      end
   end
   wire bus_rise = clk_sync[1] & ~clk_sync[2];
   wire bus_fall = ~clk_sync[1] & clk_sync[2];
   wire cmd_s = cmd_sync[1];

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   cbis_pkg::cbis_card_t card_state;
   cbis_pkg::cbis_ph_t ph;
   cbis_pkg::cbis_ph_t resp_next;
   cbis_pkg::cbis_ph_t wait_next;
   logic [47:0] rx_sh;
   logic [47:0] tx_sh;
   logic [5:0] cnt;
   logic [7:0] pwr_cnt;
   logic [7:0] pat [0:7];
   logic pend_valid;
   logic [7:0] pend_idx;
   logic [7:0] pend_val;
   logic [7:0] power_class;
   logic ctrl_sector;
   logic [3:0] busy_len;

   function automatic logic [6:0] crc7(input logic [39:0] d);
      logic [6:0] c;
      logic fb;
      c = 7'h00;
      for (int i = 39; i >= 0; i--) begin
         fb = d[i] ^ c[6];
         c = {c[5:0], 1'b0};
         if (fb) begin
            c = c ^ cbis_pkg::CRC7_POLY;
         end
      end
      return c;
   endfunction

   // ----------------------------------------------------------------
   // command decode and response frames
   // ----------------------------------------------------------------
   wire [5:0] cmd_idx = rx_sh[45:40];
   wire [31:0] cmd_arg = rx_sh[39:8];
   wire frame_ok = ~rx_sh[47] & rx_sh[46];
   wire pwr_done = (pwr_cnt == cbis_pkg::POWERUP_CLKS);
   wire volt_ok = |(cmd_arg[23:0] & cbis_pkg::OCR_VOLTAGE);
   wire is_ready = (card_state == cbis_pkg::CARD_READY);
   wire is_op_cond = frame_ok && cmd_idx == cbis_pkg::CMD_OP_COND
                     && card_state != cbis_pkg::CARD_INACTIVE;
   wire is_switch = frame_ok && is_ready && cmd_idx == cbis_pkg::CMD_SWITCH;
   wire is_test_w = frame_ok && is_ready && cmd_idx == cbis_pkg::CMD_BUSTEST_W;
   wire is_test_r = frame_ok && is_ready && cmd_idx == cbis_pkg::CMD_BUSTEST_R;
   wire [31:0] ocr = {pwr_done, ctrl_sector, 6'h00, cbis_pkg::OCR_VOLTAGE};
   wire [47:0] r3_frame = {2'b00, cbis_pkg::R3_RSVD_IDX, ocr, cbis_pkg::R3_RSVD_CRC, 1'b1};
   wire [39:0] r1_head = {2'b00, cmd_idx, 19'h0, cbis_pkg::R1_STATE_TRAN, 9'h0};
   wire [47:0] r1_frame = {r1_head, crc7(r1_head), 1'b1};
   wire [2:0] col_idx = cnt[2:0] - 3'h1;
   wire busy_end = (ph == cbis_pkg::PH_BUSY) && bus_fall && cnt == {2'h0, busy_len};
   wire pend_write = cmd_arg[25:24] == cbis_pkg::SWITCH_WRITE_BYTE;

   // power-up progress counted on rising bus clock edges seen since reset
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pwr_cnt <= 8'h00;
      end else if (bus_rise && !pwr_done) begin
         pwr_cnt <= pwr_cnt + 8'h01;
      end
   end

   // ----------------------------------------------------------------
   // link sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         card_state <= cbis_pkg::CARD_IDLE;
         ph <= cbis_pkg::PH_RX;
         resp_next <= cbis_pkg::PH_RX;
         wait_next <= cbis_pkg::PH_TXRSP;
         rx_sh <= 48'h0;
         tx_sh <= 48'h0;
         cnt <= 6'h00;
         o_cmd <= 1'b1;
         o_cmd_oe <= 1'b0;
         o_dat <= 8'hff;
         o_dat_oe <= 8'h00;
         pend_valid <= 1'b0;
         pend_idx <= 8'h00;
         pend_val <= 8'h00;
         o_timing_select_byte <= 1'b0;
         o_bus_width <= 8'h00;
         power_class <= 8'h00;
         for (int k = 0; k < 8; k++) begin
            pat[k] <= 8'h00;
         end
      end else begin
         unique case (ph)
            cbis_pkg::PH_RX: begin
               if (bus_rise && (cnt != 6'h00 || !cmd_s)) begin
                  rx_sh <= {rx_sh[46:0], cmd_s};
                  cnt <= (cnt == cbis_pkg::CMD_BITS - 6'h01) ? 6'h00 : cnt + 6'h01;
                  if (cnt == cbis_pkg::CMD_BITS - 6'h01) begin
                     ph <= cbis_pkg::PH_DECODE;
                  end
               end
            end
            cbis_pkg::PH_DECODE: begin
               wait_next <= cbis_pkg::PH_TXRSP;
               resp_next <= cbis_pkg::PH_RX;
               tx_sh <= r1_frame;
               ph <= cbis_pkg::PH_WAIT;
               if (is_op_cond && !volt_ok) begin
                  card_state <= cbis_pkg::CARD_INACTIVE;
                  ph <= cbis_pkg::PH_RX;
               end else if (is_op_cond) begin
                  tx_sh <= r3_frame;
                  if (pwr_done) begin
                     card_state <= cbis_pkg::CARD_READY;
                  end
               end else if (is_switch) begin
                  pend_valid <= pend_write;
                  pend_idx <= cmd_arg[23:16];
                  pend_val <= cmd_arg[15:8];
                  resp_next <= cbis_pkg::PH_BUSY;
               end else if (is_test_w) begin
                  resp_next <= cbis_pkg::PH_RXBLK;
               end else if (is_test_r) begin
                  resp_next <= cbis_pkg::PH_WAIT;
               end else begin
                  ph <= cbis_pkg::PH_RX;
               end
            end
            cbis_pkg::PH_WAIT: begin
               if (bus_fall) begin
                  cnt <= (cnt == cbis_pkg::NCR_CLKS - 6'h01) ? 6'h00 : cnt + 6'h01;
                  if (cnt == cbis_pkg::NCR_CLKS - 6'h01) begin
                     ph <= wait_next;
                  end
               end
            end
            cbis_pkg::PH_TXRSP: begin
               if (bus_fall && cnt == cbis_pkg::CMD_BITS) begin
                  o_cmd_oe <= 1'b0;
                  o_cmd <= 1'b1;
                  cnt <= 6'h00;
                  wait_next <= cbis_pkg::PH_TXBLK;
                  ph <= resp_next;
               end else if (bus_fall) begin
                  o_cmd <= tx_sh[47];
                  o_cmd_oe <= 1'b1;
                  tx_sh <= {tx_sh[46:0], 1'b0};
                  cnt <= cnt + 6'h01;
               end
            end
            cbis_pkg::PH_BUSY: begin
               if (busy_end) begin
                  o_dat_oe[0] <= 1'b0;
                  o_dat[0] <= 1'b1;
                  cnt <= 6'h00;
                  pend_valid <= 1'b0;
                  ph <= cbis_pkg::PH_RX;
                  // configuration takes effect only as busy is released
                  if (pend_valid && pend_idx == cbis_pkg::IDX_TIMING_SELECT) begin
                     o_timing_select_byte <= pend_val[0];
                  end
                  if (pend_valid && pend_idx == cbis_pkg::IDX_BUS_WIDTH) begin
                     o_bus_width <= pend_val;
                  end
                  if (pend_valid && pend_idx == cbis_pkg::IDX_POWER_CLASS) begin
                     power_class <= pend_val;
                  end
               end else if (bus_fall) begin
                  o_dat_oe[0] <= 1'b1;
                  o_dat[0] <= 1'b0;
                  cnt <= cnt + 6'h01;
               end
            end
            cbis_pkg::PH_RXBLK: begin
               // trailing crc and end bits fall into the idle command receiver
               if (bus_rise && (cnt != 6'h00 || !dat_s[0])) begin
                  if (cnt != 6'h00) begin
                     pat[col_idx] <= dat_s;
                  end
                  cnt <= (cnt == cbis_pkg::BLK_COLS) ? 6'h00 : cnt + 6'h01;
                  if (cnt == cbis_pkg::BLK_COLS) begin
                     ph <= cbis_pkg::PH_RX;
                  end
               end
            end
            cbis_pkg::PH_TXBLK: begin
               if (bus_fall) begin
                  o_dat_oe <= 8'hff;
                  cnt <= cnt + 6'h01;
                  if (cnt == 6'h00) begin
                     o_dat <= 8'h00;
                  end else if (cnt <= cbis_pkg::BLK_COLS) begin
                     o_dat <= ~pat[col_idx];
                  end else if (cnt == cbis_pkg::BLK_END) begin
                     o_dat <= 8'hff;
                  end else begin
                     o_dat_oe <= 8'h00;
                     cnt <= 6'h00;
                     ph <= cbis_pkg::PH_RX;
                  end
               end
            end
            default: begin
               ph <= cbis_pkg::PH_RX;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // register port
   // ----------------------------------------------------------------
   wire wr_ctrl = i_wr && i_addr == cbis_pkg::ADDR_CTRL;
   wire [31:0] ctrl_word = {24'h0, busy_len, 3'h0, ctrl_sector};
   wire [31:0] status_word = {8'h0, power_class, o_bus_width, 3'h0, o_timing_select_byte,
                              pwr_done, card_state};
   wire [31:0] pattern_word = {pat[3], pat[2], pat[1], pat[0]};
   wire [31:0] rd_mux = (i_addr == cbis_pkg::ADDR_CTRL) ? ctrl_word :
                        (i_addr == cbis_pkg::ADDR_STATUS) ? status_word :
                        (i_addr == cbis_pkg::ADDR_PATTERN) ? pattern_word : 32'h0;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ctrl_sector <= cbis_pkg::CTRL_SECTOR_RST;
         busy_len <= cbis_pkg::CTRL_BUSY_RST;
         o_rdata <= 32'h0;
      end else begin
         if (wr_ctrl) begin
            ctrl_sector <= i_wdata[cbis_pkg::CTRL_SECTOR_BIT];
            busy_len <= i_wdata[cbis_pkg::CTRL_BUSY_LSB +: 4];
         end
         o_rdata <= i_rd ? rd_mux : 32'h0;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   powerup_busy_a: assert property ((ph == cbis_pkg::PH_DECODE) && is_op_cond && volt_ok
      && !pwr_done |=> tx_sh[39] == 1'b0 && ph == cbis_pkg::PH_WAIT)
      else $error("busy bit set before power-up finished");
   ready_entry_a: assert property ((ph == cbis_pkg::PH_DECODE) && is_op_cond && volt_ok
      && pwr_done |=> card_state == cbis_pkg::CARD_READY && tx_sh[39])
      else $error("ready entry or busy bit wrong after power-up");
   inactive_silent_a: assert property (card_state == cbis_pkg::CARD_INACTIVE
      |-> !o_cmd_oe && ph != cbis_pkg::PH_TXRSP)
      else $error("inactive card drives the command line");
   hs_on_release_a: assert property ($changed(o_timing_select_byte)
      |-> $past(ph) == cbis_pkg::PH_BUSY && ph == cbis_pkg::PH_RX && !o_dat_oe[0])
      else $error("timing changed outside busy release");
   busy_dat0_a: assert property (ph == cbis_pkg::PH_BUSY && cnt != 6'h00
      |-> o_dat_oe[0] && !o_dat[0])
      else $error("data line 0 not held low during busy");
   test_all_lines_a: assert property (ph == cbis_pkg::PH_TXBLK && cnt != 6'h00
      |-> o_dat_oe == 8'hff)
      else $error("bus test answer not on all eight lines");

   ready_c: cover property ($rose(card_state == cbis_pkg::CARD_READY));
   hs_switch_c: cover property ($rose(o_timing_select_byte));
   test_block_c: cover property (ph == cbis_pkg::PH_TXBLK ##1 ph == cbis_pkg::PH_RX);
   powerup_poll_c: cover property (ph == cbis_pkg::PH_DECODE && is_op_cond && !pwr_done);
endmodule

// File: test/cbis_host.sv
// host controller model: bus clock, command frames, test blocks, busy wait
`timescale 1ns/10ps
module cbis_host (
   // card drive
   input wire logic i_card_cmd,
   input wire logic i_card_cmd_oe,
   input wire logic [7:0] i_card_dat,
   input wire logic [7:0] i_card_dat_oe,
   // resolved bus
   output logic o_bus_clk,
   output logic o_cmd_w,
   output logic [7:0] o_dat_w
);
   logic host_cmd = 1'b1;
   logic host_cmd_oe = 1'b0;
   logic [7:0] host_dat = 8'hff;
   logic [7:0] host_dat_oe = 8'h00;
   logic s_cmd;
   logic [7:0] s_dat;
   // half period: 400 kHz until the timing switch, then the working rate
   int half_ns = 1250;
   // pull-ups lift every released line
   assign o_cmd_w = i_card_cmd_oe ? i_card_cmd : (host_cmd_oe ? host_cmd : 1'b1);
   assign o_dat_w = (i_card_dat_oe & i_card_dat) | (~i_card_dat_oe & ~host_dat_oe)
      | (~i_card_dat_oe & host_dat_oe & host_dat);
   // clock idles high, runs only inside tasks
   initial o_bus_clk = 1'b1;
   function automatic logic [6:0] crc7(input logic [39:0] d);
      logic [6:0] c;
      c = 7'h00;
      for (int i = 39; i >= 0; i--) begin
         c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? cbis_pkg::CRC7_POLY : 7'h00);
      end
      return c;
   endfunction
   // sample just before the fall, drive after it
   task automatic tick();
      s_cmd = o_cmd_w;
      s_dat = o_dat_w;
      o_bus_clk = 1'b0;
      #(half_ns);
      o_bus_clk = 1'b1;
      #(half_ns);
   endtask
   task automatic power_on();
      half_ns = 1250;
      #1_000_000;
      repeat (74) tick();
   endtask
   task automatic send_cmd(input logic [5:0] idx, input logic [31:0] arg);
      logic [47:0] f;
      f = {2'b01, idx, arg, crc7({2'b01, idx, arg}), 1'b1};
      #37;
      repeat (8) tick();
      host_cmd_oe = 1'b1;
      for (int i = 47; i >= 0; i--) begin
         host_cmd = f[i];
         tick();
      end
      host_cmd_oe = 1'b0;
   endtask
   task automatic get_resp(output logic [47:0] r, output logic got);
      r = '0;
      got = 1'b0;
      for (int i = 0; i < 32 && !got; i++) begin
         tick();
         got = (s_cmd == 1'b0);
      end
      for (int i = 46; i >= 0 && got; i--) begin
         tick();
         r[i] = s_cmd;
      end
   endtask
   task automatic op_cond(input logic [31:0] arg, output logic [47:0] r, output logic got);
      r = '0;
      got = 1'b1;
      for (int i = 0; i < 8 && got && !r[39]; i++) begin
         send_cmd(cbis_pkg::CMD_OP_COND, arg);
         get_resp(r, got);
      end
   endtask
   task automatic send_blk(input logic [7:0] lanes, input logic [63:0] pat);
      repeat (4) tick();
      host_dat_oe = lanes;
      host_dat = 8'h00;
      tick();
      for (int c = 0; c < 8; c++) begin
         host_dat = pat[c*8 +: 8];
         tick();
      end
      host_dat = 8'hff;
      tick();
      host_dat_oe = 8'h00;
      repeat (4) tick();
   endtask
   task automatic rd_blk(output logic [79:0] cols);
      logic got;
      got = 1'b0;
      for (int i = 0; i < 64 && !got; i++) begin
         tick();
         got = (s_dat == 8'h00);
      end
      cols[7:0] = s_dat;
      for (int c = 1; c < 10; c++) begin
         tick();
         cols[c*8 +: 8] = s_dat;
      end
   endtask
   // counts low samples; fixed span outlasts any busy length
   task automatic busy_wait(output int n);
      n = 0;
      for (int i = 0; i < 40; i++) begin
         tick();
         n += (s_dat[0] == 1'b0);
      end
   endtask
endmodule

// File: test/testbench.sv
// self-checking bench for the card bring-up responder
`timescale 1ns/10ps
module testbench;
   logic i_clk;
   logic i_reset_n = 1'b0;
   logic [3:0] i_addr = 4'h0;
   logic [31:0] i_wdata = 32'h0;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [31:0] o_rdata;
   logic i_bus_clk, i_cmd, o_cmd, o_cmd_oe, o_timing_select_byte;
   logic [7:0] i_dat, o_dat, o_dat_oe, o_bus_width;
   int miscompares = 0;
   int n_checks = 0;
   cbis_card u_cbis_card (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_bus_clk(i_bus_clk),
      .i_cmd(i_cmd), .o_cmd(o_cmd), .o_cmd_oe(o_cmd_oe), .i_dat(i_dat), .o_dat(o_dat),
      .o_dat_oe(o_dat_oe), .o_timing_select_byte(o_timing_select_byte), .o_bus_width(o_bus_width));
   cbis_host u_cbis_host (.i_card_cmd(o_cmd), .i_card_cmd_oe(o_cmd_oe), .i_card_dat(o_dat),
      .i_card_dat_oe(o_dat_oe), .o_bus_clk(i_bus_clk), .o_cmd_w(i_cmd), .o_dat_w(i_dat));
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic results();
      if (miscompares == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic do_reset();
      i_reset_n <= 1'b0;
      repeat (12) @(posedge i_clk);
      i_reset_n <= 1'b1;
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
      @(posedge i_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      check(o_rdata, e);
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      check({o_cmd_oe, o_dat_oe, o_timing_select_byte, o_bus_width}, 18'h0);
      rd_chk(cbis_pkg::ADDR_CTRL, 32'h00000080);
      rd_chk(cbis_pkg::ADDR_STATUS, 32'h00000001);
      rd_chk(4'hc, 32'h0);
      reg_wr(cbis_pkg::ADDR_STATUS, 32'hffffffff);
      reg_wr(cbis_pkg::ADDR_CTRL, 32'h00000031);
      rd_chk(cbis_pkg::ADDR_STATUS, 32'h00000001);
      rd_chk(cbis_pkg::ADDR_CTRL, 32'h00000031);
   endtask
   task automatic t_powerup(input logic [31:0] arg, input logic [31:0] ocr);
      logic [47:0] r;
      logic got;
      u_cbis_host.power_on();
      u_cbis_host.send_cmd(cbis_pkg::CMD_OP_COND, arg);
      u_cbis_host.get_resp(r, got);
      check({got, r[39:8]}, {1'b1, 1'b0, ocr[30:0]});
      u_cbis_host.op_cond(arg, r, got);
      check(r[39:8], ocr);
      check({r[47:40], r[7:0]}, 16'h3fff);
      rd_chk(cbis_pkg::ADDR_STATUS, 32'h0000000a);
   endtask
   task automatic t_ident();
      logic [47:0] r;
      logic got;
      // last three: password unlock, clear of the old one, then the new one
      logic [5:0] idx [8] = '{6'h02, 6'h03, 6'h09, 6'h07, 6'h08, 6'h2a, 6'h2a, 6'h2a};
      for (int i = 0; i < 8; i++) begin
         u_cbis_host.send_cmd(idx[i], 32'h00020000);
         u_cbis_host.get_resp(r, got);
         check(got, 1'b0);
      end
   endtask
   task automatic t_switch(input logic [7:0] idx, input logic [7:0] val);
      logic [47:0] r;
      logic got;
      int n;
      u_cbis_host.send_cmd(cbis_pkg::CMD_SWITCH, {6'h0, cbis_pkg::SWITCH_WRITE_BYTE, idx, val, 8'h0});
      u_cbis_host.get_resp(r, got);
      check({r[45:40], r[20:17]}, {cbis_pkg::CMD_SWITCH, cbis_pkg::R1_STATE_TRAN});
      check(r[7:1], u_cbis_host.crc7(r[47:8]));
      u_cbis_host.busy_wait(n);
      check(n, 3);
   endtask
   task automatic t_speed();
      t_switch(cbis_pkg::IDX_TIMING_SELECT, 8'h01);
      check(o_timing_select_byte, 1'b1);
      u_cbis_host.half_ns = 400;
      t_switch(cbis_pkg::IDX_POWER_CLASS, 8'h02);
      t_switch(cbis_pkg::IDX_BUS_WIDTH, 8'h02);
      check(o_bus_width, 8'h02);
      rd_chk(cbis_pkg::ADDR_STATUS, 32'h0002021a);
   endtask
   task automatic t_bustest(input logic [7:0] lanes, input logic [63:0] pat);
      logic [47:0] r;
      logic got;
      logic [79:0] rx;
      logic [63:0] wire_c;
      logic [7:0] res;
      for (int c = 0; c < 8; c++) wire_c[c*8 +: 8] = (pat[c*8 +: 8] & lanes) | ~lanes;
      u_cbis_host.send_cmd(cbis_pkg::CMD_BUSTEST_W, 32'h0);
      u_cbis_host.get_resp(r, got);
      check(got, 1'b1);
      u_cbis_host.send_blk(lanes, pat);
      rd_chk(cbis_pkg::ADDR_PATTERN, wire_c[31:0]);
      u_cbis_host.send_cmd(cbis_pkg::CMD_BUSTEST_R, 32'h0);
      u_cbis_host.get_resp(r, got);
      u_cbis_host.rd_blk(rx);
      check(rx[71:8], ~wire_c);
      check({rx[79:72], rx[7:0]}, 16'hff00);
      res = 8'h00;
      for (int c = 0; c < 2; c++) res |= ~(rx[(c+1)*8 +: 8] ^ pat[c*8 +: 8]) & lanes;
      check(res, 8'h00);
   endtask
   task automatic t_inactive();
      logic [47:0] r;
      logic got;
      do_reset();
      u_cbis_host.power_on();
      u_cbis_host.send_cmd(cbis_pkg::CMD_OP_COND, 32'h80000000);
      u_cbis_host.get_resp(r, got);
      check(got, 1'b0);
      rd_chk(cbis_pkg::ADDR_STATUS, 32'h0000000c);
      u_cbis_host.send_cmd(cbis_pkg::CMD_OP_COND, 32'hc0ff8080);
      u_cbis_host.get_resp(r, got);
      check(got, 1'b0);
   endtask
   initial begin
      do_reset();
      t_regs();
      t_powerup(32'hc0ff8080, 32'hc0ff8080);
      t_ident();
      t_speed();
      t_bustest(8'hff, 64'h0000_0000_0000_aa55);
      t_bustest(8'h0f, 64'h0000_0000_0000_0a05);
      t_bustest(8'h01, 64'h0000_0000_0000_0001);
      t_inactive();
      do_reset();
      t_powerup(32'h00000080, 32'h80ff8080);
      results();
   end
   // run needs about eight million ns; margin on top
   initial begin
      #9_500_000;
      miscompares++;
      results();
   end
endmodule
